// >>> bench/i2c_link_monitor.sv
// Concurrent checks on the two-wire link between bus master and memory port
`timescale 1ns/100ps
module i2c_link_monitor #(
  parameter int NV_WRITE_CYCLES = 50
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic scl_line,
  input wire logic sda_line,
  input wire logic dev_sda_out,
  input wire logic dev_sda_oe_n,
  input wire logic nv_busy
);
  // ------------------------------------------------------------
  // Helper state
  // ------------------------------------------------------------
  logic       scl_q_r;
  logic       sda_q_r;
  logic [7:0] bit_cnt_r;
  int         busy_cnt_r;

  // Bits since the last start, saturating so long reads never wrap to zero
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      scl_q_r    <= 1'b1;
      sda_q_r    <= 1'b1;
      bit_cnt_r  <= 8'h00;
      busy_cnt_r <= 0;
    end else begin
      scl_q_r    <= scl_line;
      sda_q_r    <= sda_line;
      busy_cnt_r <= nv_busy ? busy_cnt_r + 1 : 0;
      if (scl_line && scl_q_r && sda_q_r && !sda_line) begin
        bit_cnt_r <= 8'h00;
      end else if (scl_line && !scl_q_r && bit_cnt_r != 8'hFF) begin
        bit_cnt_r <= bit_cnt_r + 8'h01;
      end
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  drive_zero_a: assert property (!dev_sda_oe_n |-> !dev_sda_out && !sda_line)
    else $error("device drive did not pull the data line low");
  change_low_a: assert property (!$stable(dev_sda_oe_n) |-> !scl_line)
    else $error("device changed data while clock high");
  no_early_a: assert property (!dev_sda_oe_n |-> bit_cnt_r >= 8'h08)
    else $error("device drove data before the ninth bit");
  start_quiet_a: assert property (scl_line && $fell(sda_line) |-> dev_sda_oe_n [*8])
    else $error("device drove data at a start");
  stop_quiet_a: assert property (scl_line && $rose(sda_line) |-> dev_sda_oe_n [*8])
    else $error("device drove data after a stop");
  busy_silent_a: assert property (nv_busy |-> dev_sda_oe_n)
    else $error("device answered during write time");
  busy_idle_a: assert property ($rose(nv_busy) |-> scl_line && sda_line)
    else $error("write time began on a busy bus");
  busy_len_a: assert property ($fell(nv_busy) |-> busy_cnt_r == NV_WRITE_CYCLES)
    else $error("write time has the wrong length");
endmodule // i2c_link_monitor

// >>> bench/tb.sv
// Self-checking bench: bus master and memory port joined over the link
`timescale 1ns/100ps
module tb;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  localparam int          NV_SIM  = 600;
  localparam logic [11:0] c_start = 12'h100;
  localparam logic [11:0] c_stop  = 12'h200;
  localparam logic [11:0] c_read  = 12'h400;
  localparam logic [11:0] c_nack  = 12'h800;
  logic        clk_sys;
  logic        rst_n;
  logic [3:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic        nv_busy;
  logic [7:0]  main_address;
  logic        main_select_en;
  logic [15:0] st;
  int          fail_count = 0;
  int          n_compared = 0;
  int          cycles = 0;

  i2c_link_if link ();
  i2c_mem_port #(.NV_WRITE_CYCLES(NV_SIM)) u_i2c_mem_port (.clk_sys(clk_sys), .rst_n(rst_n),
    .link(link), .nv_busy(nv_busy), .main_address(main_address),
    .main_select_en(main_select_en));
  // Short quarters keep the run brief; eight is the safe floor
  i2c_bus_master #(.QUARTER_CYCLES(8)) u_i2c_bus_master (.clk_sys(clk_sys), .rst_n(rst_n),
    .link(link), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  i2c_link_monitor #(.NV_WRITE_CYCLES(NV_SIM)) u_i2c_link_monitor (.clk_sys(clk_sys),
    .rst_n(rst_n), .scl_line(link.scl_line), .sda_line(link.sda_line),
    .dev_sda_out(link.dev_sda_out), .dev_sda_oe_n(link.dev_sda_oe_n), .nv_busy(nv_busy));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask

  // Issue one command, then poll status until the master is idle
  task automatic cmd(input logic [11:0] c);
    int n;
    n = 0;
    @(posedge clk_sys);
    addr <= i2c_pkg::CMD_OFS;
    wdata <= {4'h0, c};
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
    do begin
      addr <= i2c_pkg::STAT_OFS;
      rd <= 1'b1;
      @(posedge clk_sys);
      rd <= 1'b0;
      @(negedge clk_sys);
      st = rdata;
      @(posedge clk_sys);
      n++;
    end while (st[i2c_pkg::STAT_BUSY_BIT] !== 1'b0 && n < 300);
    // A master that never goes idle is a hang, so it counts against the run
    if (st[i2c_pkg::STAT_BUSY_BIT] !== 1'b0) begin
      $display("wrong value master busy expected 0 seen %b", st[i2c_pkg::STAT_BUSY_BIT]);
      fail_count++;
    end
  endtask

  task automatic put(input logic [11:0] c, input logic exp_nack);
    cmd(c);
    check("ninth bit", {7'h00, exp_nack}, {7'h00, st[i2c_pkg::STAT_NACK_BIT]});
  endtask

  task automatic get(input logic [11:0] c, input logic [7:0] exp);
    cmd(c | c_read);
    check("read byte", exp, st[15:8]);
  endtask

  // Bounded wait for the write time to run out
  task automatic wait_idle();
    int n;
    n = 0;
    while (nv_busy !== 1'b0 && n < 2000) begin
      @(posedge clk_sys);
      n++;
    end
    // A write time that never ends counts as a mismatch
    if (nv_busy !== 1'b0) begin
      $display("wrong value nv_busy expected 0 seen %b", nv_busy);
      fail_count++;
    end
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    check("main_address", i2c_pkg::MAIN_ADDR_RESET, main_address);
    check("select_en", 8'h01, {7'h00, main_select_en});
    @(posedge clk_sys);
    addr <= 4'h8;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    @(negedge clk_sys);
    check("unmapped read", 8'h00, rdata[7:0]);
  endtask

  // Row wrap on a page write, ack polling, then random and sequential reads
  task automatic t_page();
    put(c_start | 12'h0A2, 1'b0);
    put(12'h006, 1'b0);
    put(12'h011, 1'b0);
    put(12'h022, 1'b0);
    put(c_stop | 12'h033, 1'b0);
    check("nv_busy", 8'h01, {7'h00, nv_busy});
    put(c_start | c_stop | 12'h0A2, 1'b1);
    wait_idle();
    put(c_start | 12'h0A2, 1'b0);
    put(12'h006, 1'b0);
    put(c_start | 12'h0A3, 1'b0);
    get(12'h000, 8'h11);
    get(12'h000, 8'h22);
    get(c_nack | c_stop, 8'h00);
    put(c_start | 12'h0A2, 1'b0);
    put(12'h000, 1'b0);
    put(c_start | 12'h0A3, 1'b0);
    get(c_nack | c_stop, 8'h33);
  endtask

  // A foreign address is ignored for the rest of the transfer
  task automatic t_ignore();
    put(c_start | 12'h050, 1'b1);
    put(c_stop | 12'h006, 1'b1);
    check("nv_busy", 8'h00, {7'h00, nv_busy});
  endtask

  // Main address moved onto the auxiliary one, then its enable cleared
  task automatic t_readdr();
    put(c_start | 12'h0A2, 1'b0);
    put(12'h08C, 1'b0);
    put(c_stop | 12'h0A0, 1'b0);
    check("main_address", 8'hA0, main_address);
    wait_idle();
    put(c_start | 12'h0A0, 1'b0);
    put(12'h006, 1'b0);
    put(c_start | 12'h0A1, 1'b0);
    get(c_nack | c_stop, 8'h11);
    put(c_start | 12'h0A0, 1'b0);
    put(12'h089, 1'b0);
    put(c_stop | 12'h000, 1'b0);
    check("select_en", 8'h00, {7'h00, main_select_en});
    wait_idle();
    put(c_start | 12'h0A0, 1'b0);
    put(12'h006, 1'b0);
    put(c_start | 12'h0A1, 1'b0);
    get(c_nack | c_stop, 8'h00);
  endtask

  // ------------------------------------------------------------
  // Clock, run control and verdict
  // ------------------------------------------------------------
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Ceiling well above the roughly 12000 cycles the scenarios need
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      fail_count++;
      test_done();
    end
  end

  initial begin
    rst_n = 1'b0;
    addr = 4'h0;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset();
    t_page();
    t_ignore();
    t_readdr();
    test_done();
  end
endmodule // tb

// >>> hdl/i2c_bus_master.sv
// Byte-level two-wire bus master driven from a small command port
`timescale 1ns/100ps
module i2c_bus_master #(
  parameter int QUARTER_CYCLES = i2c_pkg::QUARTER_CYCLES
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  i2c_link_if.master       link,
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata
);
  localparam int QW = $clog2(QUARTER_CYCLES + 1);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef enum logic [1:0] {IDLE, START, BITS, STOP} mst_type;

  typedef struct packed {
    logic [QW-1:0] q;
    logic [1:0]    ph;
    mst_type       st;
    logic [3:0]    bit_cnt;
    logic [7:0]    tx;
    logic [7:0]    rx;
    logic          rd_mode;
    logic          nack_send;
    logic          stop_after;
    logic          nack_got;
    logic          scl_oe_n;
    logic          sda_oe_n;
    logic [2:0]    s_sda;
    logic          sda;
    logic [15:0]   rdata;
  } mstate_type;

  mstate_type r;
  mstate_type n;
  logic       tick;

  always_comb begin
    n = r;
    // Same three-stage filter as the slave; the bus is slow beside it
    n.s_sda = {r.s_sda[1:0], link.sda_line};
    if (r.s_sda[1] == r.s_sda[2]) begin
      n.sda = r.s_sda[2];
    end
    tick = (r.q == QW'(QUARTER_CYCLES - 1));

    // Command port; a command written while busy is dropped
    n.rdata = 16'h0000;
    if (rd && addr == i2c_pkg::STAT_OFS) begin
      n.rdata[i2c_pkg::STAT_BUSY_BIT] = (r.st != IDLE);
      n.rdata[i2c_pkg::STAT_NACK_BIT] = r.nack_got;
      n.rdata[i2c_pkg::STAT_RX_LSB +: 8] = r.rx;
    end
    if (wr && addr == i2c_pkg::CMD_OFS && r.st == IDLE) begin
      n.tx         = wdata[7:0];
      n.rd_mode    = wdata[i2c_pkg::CMD_READ_BIT];
      n.nack_send  = wdata[i2c_pkg::CMD_NACK_BIT];
      n.stop_after = wdata[i2c_pkg::CMD_STOP_BIT];
      n.st         = wdata[i2c_pkg::CMD_START_BIT] ? START : BITS;
      n.bit_cnt    = 4'h0;
      n.q          = '0;
      n.ph         = 2'h0;
    end else if (r.st != IDLE) begin
      n.q = tick ? '0 : r.q + 1'b1;
      if (tick) begin
        n.ph = r.ph + 2'h1;
        case (r.st)
          START: begin
            // Release data first so a repeated start also works
            case (r.ph)
              2'h0: n.sda_oe_n = 1'b1;
              2'h1: n.scl_oe_n = 1'b1;
              2'h2: n.sda_oe_n = 1'b0;
              default: begin
                n.scl_oe_n = 1'b0;
                n.st       = BITS;
              end
            endcase
          end
          BITS: begin
            case (r.ph)
              2'h0: begin
                if (r.bit_cnt < i2c_pkg::BITS_PER_BYTE) begin
                  n.sda_oe_n = r.rd_mode | r.tx[7];
                end else begin
                  n.sda_oe_n = !r.rd_mode | r.nack_send;
                end
              end
              2'h1: n.scl_oe_n = 1'b1;
              2'h2: begin
                if (r.bit_cnt < i2c_pkg::BITS_PER_BYTE) begin
                  n.rx = {r.rx[6:0], r.sda};
                end else if (!r.rd_mode) begin
                  n.nack_got = r.sda;
                end
              end
              default: begin
                n.scl_oe_n = 1'b0;
                n.tx       = {r.tx[6:0], 1'b0};
                n.bit_cnt  = r.bit_cnt + 4'h1;
                if (r.bit_cnt == i2c_pkg::BITS_PER_BYTE) begin
                  n.st = r.stop_after ? STOP : IDLE;
                end
              end
            endcase
          end
          STOP: begin
            case (r.ph)
              2'h0: n.sda_oe_n = 1'b0;
              2'h1: n.scl_oe_n = 1'b1;
              2'h2: n.sda_oe_n = 1'b1;
              default: n.st = IDLE;
            endcase
          end
          default: n.st = IDLE;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      r          <= '0;
      r.st       <= IDLE;
      r.scl_oe_n <= 1'b1;
      r.sda_oe_n <= 1'b1;
      r.s_sda    <= 3'h7;
      r.sda      <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign link.mst_scl_out  = 1'b0;
  assign link.mst_sda_out  = 1'b0;
  assign link.mst_scl_oe_n = r.scl_oe_n;
  assign link.mst_sda_oe_n = r.sda_oe_n;
  assign rdata             = r.rdata;
endmodule // i2c_bus_master

// >>> hdl/i2c_link_if.sv
// Two-wire link between bus master and memory port, with open-drain resolution
`timescale 1ns/100ps
interface i2c_link_if;
  logic mst_scl_out;
  logic mst_scl_oe_n;
  logic mst_sda_out;
  logic mst_sda_oe_n;
  logic dev_sda_out;
  logic dev_sda_oe_n;
  logic scl_line;
  logic sda_line;

  // Wired-AND with pull-up: a line is low when any enabled driver drives low
  assign scl_line = !(!mst_scl_oe_n && !mst_scl_out);
  assign sda_line = !((!mst_sda_oe_n && !mst_sda_out) || (!dev_sda_oe_n && !dev_sda_out));

  modport device (input scl_line, input sda_line, output dev_sda_out, output dev_sda_oe_n);
  modport master (input  scl_line, input sda_line, output mst_scl_out, output mst_scl_oe_n,
                  output mst_sda_out, output mst_sda_oe_n);
endinterface

// >>> hdl/i2c_mem_port.sv
// Two-wire slave memory port with main and auxiliary memory spaces
//
// The strobed register port was decided locally.
`timescale 1ns/100ps
module i2c_mem_port #(
  parameter int NV_WRITE_CYCLES = i2c_pkg::NV_WRITE_CYCLES
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  i2c_link_if.device      link,
  output logic            nv_busy,
  output logic [7:0]      main_address,
  output logic            main_select_en
);
  localparam int WW = $clog2(NV_WRITE_CYCLES + 1);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    IDLE, ADDR, MEMADDR, WDATA, ACK, RDATA, RACK, IGNORE
  } phase_type;

  typedef struct packed {
    logic [2:0]        s_scl;
    logic [2:0]        s_sda;
    logic              scl;
    logic              sda;
    phase_type         st;
    phase_type         nxt;
    logic [3:0]        cnt;
    logic [7:0]        sh;
    logic [7:0]        ptr;
    logic              aux;
    logic              wrote;
    logic              mnack;
    logic              oe_n;
    logic              busy;
    logic [WW-1:0]     wait_cnt;
    logic [255:0][7:0] main_mem;
    logic [255:0][7:0] aux_mem;
  } state_type;

  state_type r;
  state_type n;

  logic       rise;
  logic       fall;
  logic       start;
  logic       stop;
  logic       sel_en;
  logic       hit_aux;
  logic       hit_main;
  logic [7:0] tx;

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb begin
    n = r;
    // Three-stage input chain; a level is taken once the last two agree
    n.s_scl = {r.s_scl[1:0], link.scl_line};
    n.s_sda = {r.s_sda[1:0], link.sda_line};
    if (r.s_scl[1] == r.s_scl[2]) begin
      n.scl = r.s_scl[2];
    end
    if (r.s_sda[1] == r.s_sda[2]) begin
      n.sda = r.s_sda[2];
    end

    rise  = n.scl & ~r.scl;
    fall  = ~n.scl & r.scl;
    start = r.scl & n.scl & r.sda & ~n.sda;
    stop  = r.scl & n.scl & ~r.sda & n.sda;

    // Address decode on the received first byte
    sel_en   = r.main_mem[i2c_pkg::SELECT_EN_REG][i2c_pkg::SELECT_EN_BIT];
    hit_main = sel_en && (r.sh[7:1] == r.main_mem[i2c_pkg::MAIN_ADDR_REG][7:1]);
    hit_aux  = (r.sh[7:1] == i2c_pkg::AUX_ADDR[7:1])
             && !(sel_en && r.main_mem[i2c_pkg::MAIN_ADDR_REG] == i2c_pkg::AUX_ADDR);
    tx       = r.aux ? r.aux_mem[r.ptr] : r.main_mem[r.ptr];

    // Nonvolatile write timer
    if (r.busy) begin
      n.wait_cnt = r.wait_cnt - 1'b1;
      if (r.wait_cnt == WW'(1)) begin
        n.busy = 1'b0;
      end
    end

    if (start) begin
      // A start resets the byte machine from any phase, also mid-transfer
      n.st   = ADDR;
      n.cnt  = 4'h0;
      n.oe_n = 1'b1;
    end else if (stop) begin
      n.st   = IDLE;
      n.oe_n = 1'b1;
      if (r.wrote) begin
        n.busy     = 1'b1;
        n.wait_cnt = WW'(NV_WRITE_CYCLES);
        n.wrote    = 1'b0;
      end
    end else if (rise) begin
      case (r.st)
        ADDR, MEMADDR, WDATA: begin
          n.sh  = {r.sh[6:0], n.sda};
          n.cnt = r.cnt + 4'h1;
        end
        RACK: begin
          n.mnack = n.sda;
        end
        default: begin
        end
      endcase
    end else if (fall) begin
      case (r.st)
        ADDR: begin
          if (r.cnt == i2c_pkg::BITS_PER_BYTE) begin
            if (!r.busy && (hit_aux || hit_main)) begin
              n.aux  = hit_aux;
              n.oe_n = 1'b0;
              n.st   = ACK;
              n.nxt  = r.sh[0] ? RDATA : MEMADDR;
            end else begin
              n.st = IGNORE;
            end
          end
        end
        MEMADDR: begin
          if (r.cnt == i2c_pkg::BITS_PER_BYTE) begin
            n.ptr  = r.sh;
            n.oe_n = 1'b0;
            n.st   = ACK;
            n.nxt  = WDATA;
          end
        end
        WDATA: begin
          if (r.cnt == i2c_pkg::BITS_PER_BYTE) begin
            if (r.aux) begin
              n.aux_mem[r.ptr] = r.sh;
            end else begin
              n.main_mem[r.ptr] = r.sh;
            end
            // Only the low three bits advance so the counter stays in its row
            n.ptr   = {r.ptr[7:3], r.ptr[2:0] + 3'h1};
            n.wrote = 1'b1;
            n.oe_n  = 1'b0;
            n.st    = ACK;
            n.nxt   = WDATA;
          end
        end
        ACK: begin
          n.cnt = 4'h0;
          if (r.nxt == RDATA) begin
            n.sh   = tx;
            n.oe_n = tx[7];
            n.st   = RDATA;
          end else begin
            n.oe_n = 1'b1;
            n.st   = r.nxt;
          end
        end
        RDATA: begin
          if (r.cnt == i2c_pkg::LAST_TX_BIT) begin
            n.oe_n = 1'b1;
            n.st   = RACK;
            n.ptr  = r.ptr + 8'h01;
          end else begin
            n.cnt  = r.cnt + 4'h1;
            n.sh   = {r.sh[6:0], 1'b0};
            n.oe_n = r.sh[6];
          end
        end
        RACK: begin
          if (r.mnack) begin
            // Master is done; line stays released until stop or start
            n.st = IGNORE;
          end else begin
            n.cnt  = 4'h0;
            n.sh   = tx;
            n.oe_n = tx[7];
            n.st   = RDATA;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      r          <= '0;
      r.s_scl    <= 3'h7;
      r.s_sda    <= 3'h7;
      r.scl      <= 1'b1;
      r.sda      <= 1'b1;
      r.st       <= IDLE;
      r.nxt      <= IDLE;
      r.oe_n     <= 1'b1;
      r.main_mem[i2c_pkg::MAIN_ADDR_REG] <= i2c_pkg::MAIN_ADDR_RESET;
      r.main_mem[i2c_pkg::SELECT_EN_REG] <= i2c_pkg::SELECT_EN_RESET;
    end else begin
      r <= n;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Open drain: the pin is only ever pulled low, a one is a release
  assign link.dev_sda_out  = 1'b0;
  assign link.dev_sda_oe_n = r.oe_n;
  assign nv_busy           = r.busy;
  assign main_address      = r.main_mem[i2c_pkg::MAIN_ADDR_REG];
  assign main_select_en    = r.main_mem[i2c_pkg::SELECT_EN_REG][i2c_pkg::SELECT_EN_BIT];
endmodule // i2c_mem_port

// >>> hdl/i2c_pkg.sv
// Shared constants for the two-wire memory port and its bus master
package i2c_pkg;
  // ------------------------------------------------------------
  // Slave addressing and memory layout
  // ------------------------------------------------------------
  localparam logic [7:0] AUX_ADDR        = 8'hA0;
  localparam logic [7:0] MAIN_ADDR_REG   = 8'h8C;
  localparam logic [7:0] SELECT_EN_REG   = 8'h89;
  localparam int         SELECT_EN_BIT   = 0;
  localparam logic [7:0] MAIN_ADDR_RESET = 8'hA2;
  localparam logic [7:0] SELECT_EN_RESET = 8'h01;
  localparam logic [3:0] BITS_PER_BYTE   = 4'h8;
  localparam logic [3:0] LAST_TX_BIT     = 4'h7;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int SYS_CLK_MHZ          = 100;
  localparam int NV_WRITE_TIME_US     = 10000;
  localparam int NV_WRITE_CYCLES      = NV_WRITE_TIME_US * SYS_CLK_MHZ;
  localparam int QUARTER_CYCLES       = 20;
  // ------------------------------------------------------------
  // Master command port
  // ------------------------------------------------------------
  localparam logic [3:0] CMD_OFS        = 4'h0;
  localparam logic [3:0] STAT_OFS       = 4'h4;
  localparam int         CMD_START_BIT  = 8;
  localparam int         CMD_STOP_BIT   = 9;
  localparam int         CMD_READ_BIT   = 10;
  localparam int         CMD_NACK_BIT   = 11;
  localparam int         STAT_BUSY_BIT  = 0;
  localparam int         STAT_NACK_BIT  = 1;
  localparam int         STAT_RX_LSB    = 8;
endpackage
